// file: logic/pml_lock.sv
// protection logic guarding the one-time-programmable program memory
// assumes memory array, nonvolatile lock cells and cpu fetch unit outside
//
// Contract
// [R1] Three fixed signature bytes at their dedicated addresses can be read by the programmer.
// [R2] Verify read-out of program memory works only while lock bits two and three are clear.
// [R3] With the encryption table programmed, verify data is code byte XNOR a table byte.
// [R4] No path ever lets the encryption table contents out of the block.
// [R5] With lock bit one set, a code-table read run from external code gets no internal bytes.
// [R6] With lock bit one set, external access select is latched at reset and held till next reset.
// [R7] With lock bit one set, every further programming operation is refused.
// [R8] With lock bits one and two set, verify read-out is disabled as well.
// [R9] With all three lock bits set, external program fetch and execution are blocked.
// [R10] The programmer sets lock bits only cumulatively; other combinations are undefined.
// [R11] Lock cells are captured into flags at reset and every check uses those flags.
`timescale 1ns/10ps
`include "pml_defs.svh"
module pml_lock (
  // clock and reset
  input  wire logic                   mclk_in,
  input  wire logic                   rstn_in,
  // nonvolatile lock cells and encryption table
  input  wire pml_pkg::pml_locks_t    lock_cells_in,
  input  wire logic                   enc_programmed_in,
  input  wire logic [7:0]             enc_table_in [`PML_ENC_DEPTH],
  // external access select pin
  input  wire logic                   external_access_select_in,
  // programmer verify port
  input  wire logic                   verify_req_in,
  input  wire logic [12:0]            verify_addr_in,
  input  wire logic [7:0]             code_byte_in,
  output logic                        verify_valid_out,
  output logic [7:0]                  verify_data_out,
  // programmer program port
  input  wire logic                   program_req_in,
  output logic                        program_grant_out,
  output logic                        program_refused_out,
  // cpu fetch side
  input  wire logic                   fetch_external_in,
  input  wire logic                   code_table_read_instruction_in,
  input  wire logic                   table_addr_internal_in,
  output logic                        table_read_block_out,
  output logic                        fetch_block_out,
  output logic                        ext_select_out,
  output pml_pkg::pml_level_t         level_out
);
  typedef struct packed {
    logic [1:0]            rst_sync;
    logic                  captured;
    pml_pkg::pml_locks_t   locks;
    logic                  enc_on;
    logic                  ea_latched;
    logic                  verify_valid;
    logic [7:0]            verify_data;
    logic                  prog_grant;
    logic                  prog_refused;
    logic                  table_block;
    logic                  fetch_block;
    logic                  ext_select;
    pml_pkg::pml_level_t   level;
  } pml_state_t;

  pml_state_t state_ff;
  pml_state_t nxt_state;
  logic       rst_n;
  logic [2:0] sig_hit_v;
  logic [7:0] sig_byte_v [3];

  assign rst_n = state_ff.rst_sync[1];

  // signature bytes answer at fixed addresses in every lock level
  pml_sig_slot #(
    .SLOT_ADDR (`PML_SIG_ADDR0),
    .SLOT_VAL  (`PML_SIG_VAL0)
  ) u_sig0 (
    .addr_in  (verify_addr_in),
    .hit_out  (sig_hit_v[0]),
    .byte_out (sig_byte_v[0])
  ); // R1

  pml_sig_slot #(
    .SLOT_ADDR (`PML_SIG_ADDR1),
    .SLOT_VAL  (`PML_SIG_VAL1)
  ) u_sig1 (
    .addr_in  (verify_addr_in),
    .hit_out  (sig_hit_v[1]),
    .byte_out (sig_byte_v[1])
  ); // R1

  pml_sig_slot #(
    .SLOT_ADDR (`PML_SIG_ADDR2),
    .SLOT_VAL  (`PML_SIG_VAL2)
  ) u_sig2 (
    .addr_in  (verify_addr_in),
    .hit_out  (sig_hit_v[2]),
    .byte_out (sig_byte_v[2])
  ); // R1

  always_comb begin
    logic [7:0] sig;
    logic       sig_hit;
    logic       verify_ok;
    logic [7:0] key;
    logic [2:0] lock_code;

    sig       = sig_byte_v[0] | sig_byte_v[1] | sig_byte_v[2];
    sig_hit   = |sig_hit_v;
    verify_ok = 1'b0;
    key       = `PML_BYTE_RST;
    lock_code = {state_ff.locks.lock_bit_one, state_ff.locks.lock_bit_two,
                 state_ff.locks.lock_bit_three};
    nxt_state = state_ff;

    // reset release through two stages
    nxt_state.rst_sync = {state_ff.rst_sync[0], 1'b1};

    // capture lock cells and pin once after reset release
    if (rst_n && !state_ff.captured) begin
      nxt_state.captured   = 1'b1;
      nxt_state.locks      = lock_cells_in; // R11
      nxt_state.enc_on     = enc_programmed_in;
      nxt_state.ea_latched = external_access_select_in; // R6
    end
    if (!rst_n) begin
      nxt_state.captured = 1'b0;
    end

    unique case (lock_code)
      3'b000:  nxt_state.level = pml_pkg::PML_LVL_NONE;
      3'b100:  nxt_state.level = pml_pkg::PML_LVL_ONE;
      3'b110:  nxt_state.level = pml_pkg::PML_LVL_TWO;
      3'b111:  nxt_state.level = pml_pkg::PML_LVL_THREE;
      // undefined combinations reported as fully locked on level_out; each check still uses its own lock bit
      default: nxt_state.level = pml_pkg::PML_LVL_THREE; // R10
    endcase

    // verify answer: signature, plain or mixed code
    verify_ok = state_ff.captured && !state_ff.locks.lock_bit_two
                && !state_ff.locks.lock_bit_three; // R2 R8
    key = enc_table_in[verify_addr_in[`PML_ENC_IDX_W-1:0]];
    nxt_state.verify_valid = 1'b0;
    nxt_state.verify_data  = `PML_BYTE_RST;
    if (verify_req_in && state_ff.captured) begin
      if (sig_hit) begin
        nxt_state.verify_valid = 1'b1;
        nxt_state.verify_data  = sig; // R1
      end else if (verify_ok) begin
        nxt_state.verify_valid = 1'b1;
        // table only ever leaves mixed with code, never alone
        if (state_ff.enc_on) begin
          nxt_state.verify_data = ~(code_byte_in ^ key); // R3 R4
        end else begin
          nxt_state.verify_data = code_byte_in;
        end
      end
    end

    // program requests answered one cycle later
    nxt_state.prog_grant   = 1'b0;
    nxt_state.prog_refused = 1'b0;
    if (program_req_in && state_ff.captured) begin
      if (state_ff.locks.lock_bit_one) begin
        nxt_state.prog_refused = 1'b1; // R7
      end else begin
        nxt_state.prog_grant = 1'b1; // R7
      end
    end

    // fetch side blocks
    nxt_state.table_block = 1'b0;
    nxt_state.fetch_block = 1'b0;
    if (fetch_external_in) begin
      // external code may not pull internal bytes once locked
      if (state_ff.locks.lock_bit_one && code_table_read_instruction_in
          && table_addr_internal_in) begin
        nxt_state.table_block = 1'b1; // R5
      end
      if (state_ff.locks.lock_bit_three) begin
        nxt_state.fetch_block = 1'b1; // R9
      end
    end

    // effective external access select
    if (state_ff.locks.lock_bit_one) begin
      nxt_state.ext_select = state_ff.ea_latched; // R6
    end else begin
      nxt_state.ext_select = external_access_select_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs straight from the state register
  assign verify_valid_out     = state_ff.verify_valid;
  assign verify_data_out      = state_ff.verify_data;
  assign program_grant_out    = state_ff.prog_grant;
  assign program_refused_out  = state_ff.prog_refused;
  assign table_read_block_out = state_ff.table_block;
  assign fetch_block_out      = state_ff.fetch_block;
  assign ext_select_out       = state_ff.ext_select;
  assign level_out            = state_ff.level;
endmodule

// one fixed signature byte answering at its own address
module pml_sig_slot #(
  // address it answers at and the byte it returns
  parameter logic [12:0] SLOT_ADDR = `PML_SIG_ADDR0,
  parameter logic [7:0]  SLOT_VAL  = `PML_SIG_VAL0
) (
  // verify address
  input  wire logic [12:0] addr_in,
  // match and byte, zero when no match
  output logic             hit_out,
  output logic [7:0]       byte_out
);

  assign hit_out  = (addr_in == SLOT_ADDR);
  assign byte_out = hit_out ? SLOT_VAL : `PML_BYTE_RST;
endmodule

// file: pkg/pml_defs.svh
// constants for the program memory security lock
// assumes inclusion by bare name from logic and sim files
`ifndef PML_DEFS_SVH
`define PML_DEFS_SVH
`define PML_SIG_ADDR0    13'h0030
`define PML_SIG_ADDR1    13'h0031
`define PML_SIG_ADDR2    13'h0060
`define PML_SIG_VAL0     8'hA5
`define PML_SIG_VAL1     8'h5A
`define PML_SIG_VAL2     8'h3C
`define PML_ENC_DEPTH    32
`define PML_ENC_IDX_W    5
`define PML_BYTE_RST     8'h00
`endif

// file: pkg/pml_pkg.sv
// types for the program memory security lock
// assumes pml_defs.svh on the include path
package pml_pkg;
  typedef enum logic [1:0] {
    PML_LVL_NONE,
    PML_LVL_ONE,
    PML_LVL_TWO,
    PML_LVL_THREE
  } pml_level_t;

  typedef struct packed {
    logic       lock_bit_one;
    logic       lock_bit_two;
    logic       lock_bit_three;
  } pml_locks_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } pml_byte_t;
endpackage

// file: sim/pml_prog_model.sv
// programmer side: code array behind the verify port, table cells
// assumes the bench drives the verify address
`timescale 1ns/10ps
module pml_prog_model (
  input  wire logic [12:0] addr_in,
  output logic      [7:0]  code_out,
  output logic      [7:0]  table_out [32]
);
  assign code_out = addr_in[7:0] ^ 8'h3C;
  always_comb for (int i = 0; i < 32; i++) table_out[i] = 8'hC0 | 8'(i);
endmodule

// file: sim/pml_lock_chk.sv
// port assertions for the security lock
// assumes bound into the lock block; checks start once flags are captured
`timescale 1ns/10ps
`include "pml_defs.svh"
module pml_lock_chk (
  // clock and reset
  input wire logic                 mclk_in,
  input wire logic                 rstn_in,
  // table and verify port
  input wire logic                 enc_programmed_in,
  input wire logic [7:0]           enc_table_in [`PML_ENC_DEPTH],
  input wire logic                 verify_req_in,
  input wire logic [12:0]          verify_addr_in,
  input wire logic [7:0]           code_byte_in,
  input wire logic                 verify_valid_out,
  input wire logic [7:0]           verify_data_out,
  // program port
  input wire logic                 program_req_in,
  input wire logic                 program_grant_out,
  input wire logic                 program_refused_out,
  // fetch side
  input wire logic                 fetch_external_in,
  input wire logic                 code_table_read_instruction_in,
  input wire logic                 table_addr_internal_in,
  input wire logic                 table_read_block_out,
  input wire logic                 fetch_block_out,
  input wire logic                 ext_select_out,
  input wire pml_pkg::pml_level_t  level_out
);
  // edges since reset release; flags and level settled at four
  logic [2:0] up_cnt_ff;
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      up_cnt_ff <= 3'h0;
    end else if (up_cnt_ff != 3'h4) begin
      up_cnt_ff <= up_cnt_ff + 3'h1;
    end
  end
  wire logic live = (up_cnt_ff == 3'h4);
  wire logic rd_code = verify_req_in && !(verify_addr_in inside
    {`PML_SIG_ADDR0, `PML_SIG_ADDR1, `PML_SIG_ADDR2});
  wire logic [7:0] xnor_byte = ~(code_byte_in ^ enc_table_in[verify_addr_in[4:0]]);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_locked; live && (|level_out) [*2]; endsequence
  property p_sig; live && verify_req_in && verify_addr_in == `PML_SIG_ADDR1
    |=> verify_valid_out && verify_data_out == `PML_SIG_VAL1; endproperty
  a_sig: assert property (p_sig) else $error("bad signature");
  property p_open; live && verify_req_in && !level_out[1] |=> verify_valid_out; endproperty
  a_open: assert property (p_open) else $error("no verify answer");
  property p_shut; live && rd_code && level_out[1] |=> !verify_valid_out; endproperty
  a_shut: assert property (p_shut) else $error("verify while locked");
  property p_xnor; live && rd_code && enc_programmed_in && !level_out[1]
    |=> verify_data_out == $past(xnor_byte); endproperty
  a_xnor: assert property (p_xnor) else $error("bad encrypted byte");
  property p_prog; live && program_req_in
    |=> program_refused_out == |level_out && program_grant_out == !level_out; endproperty
  a_prog: assert property (p_prog) else $error("bad program answer");
  property p_tbl; live && fetch_external_in && code_table_read_instruction_in
    && table_addr_internal_in && |level_out |=> table_read_block_out; endproperty
  a_tbl: assert property (p_tbl) else $error("table read open");
  property p_fetch; live && fetch_external_in |=> fetch_block_out == &level_out; endproperty
  a_fetch: assert property (p_fetch) else $error("bad fetch block");
  property p_ext; s_locked |=> $stable(ext_select_out); endproperty
  a_ext: assert property (p_ext) else $error("select not held");
endmodule
bind pml_lock pml_lock_chk u_chk (
  .mclk_in                        (mclk_in),
  .rstn_in                        (rstn_in),
  .enc_programmed_in              (enc_programmed_in),
  .enc_table_in                   (enc_table_in),
  .verify_req_in                  (verify_req_in),
  .verify_addr_in                 (verify_addr_in),
  .code_byte_in                   (code_byte_in),
  .verify_valid_out               (verify_valid_out),
  .verify_data_out                (verify_data_out),
  .program_req_in                 (program_req_in),
  .program_grant_out              (program_grant_out),
  .program_refused_out            (program_refused_out),
  .fetch_external_in              (fetch_external_in),
  .code_table_read_instruction_in (code_table_read_instruction_in),
  .table_addr_internal_in         (table_addr_internal_in),
  .table_read_block_out           (table_read_block_out),
  .fetch_block_out                (fetch_block_out),
  .ext_select_out                 (ext_select_out),
  .level_out                      (level_out)
);

// file: sim/tb_pml_lock.sv
// bench for the security lock, one pass per lock level
// assumes design, checker and model compiled first
`timescale 1ns/10ps
`include "pml_defs.svh"
module tb_pml_lock;
  logic mclk_in = 1'b0, rstn_in = 1'b0, enc_programmed_in, external_access_select_in;
  logic verify_req_in, program_req_in, fetch_external_in, code_table_read_instruction_in;
  logic table_addr_internal_in, verify_valid_out, program_grant_out, program_refused_out;
  logic table_read_block_out, fetch_block_out, ext_select_out;
  logic [12:0] verify_addr_in;
  logic [7:0] code_byte_in, verify_data_out, enc_table_in [32];
  pml_pkg::pml_locks_t lock_cells_in;
  pml_pkg::pml_level_t level_out;
  int num_errors = 0, tests_run = 0, cycles = 0;
  initial forever #12.5 mclk_in = ~mclk_in;
  pml_prog_model prog (.addr_in(verify_addr_in), .code_out(code_byte_in),
    .table_out(enc_table_in));
  pml_lock uut (
    .mclk_in                        (mclk_in),
    .rstn_in                        (rstn_in),
    .lock_cells_in                  (lock_cells_in),
    .enc_programmed_in              (enc_programmed_in),
    .enc_table_in                   (enc_table_in),
    .external_access_select_in      (external_access_select_in),
    .verify_req_in                  (verify_req_in),
    .verify_addr_in                 (verify_addr_in),
    .code_byte_in                   (code_byte_in),
    .verify_valid_out               (verify_valid_out),
    .verify_data_out                (verify_data_out),
    .program_req_in                 (program_req_in),
    .program_grant_out              (program_grant_out),
    .program_refused_out            (program_refused_out),
    .fetch_external_in              (fetch_external_in),
    .code_table_read_instruction_in (code_table_read_instruction_in),
    .table_addr_internal_in         (table_addr_internal_in),
    .table_read_block_out           (table_read_block_out),
    .fetch_block_out                (fetch_block_out),
    .ext_select_out                 (ext_select_out),
    .level_out                      (level_out)
  );
  task chk(input logic [7:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rd(input logic [12:0] a, input logic ok, input logic [7:0] d);
    verify_req_in = 1'b1;
    verify_addr_in = a;
    @(negedge mclk_in);
    chk(verify_valid_out, ok);
    chk(verify_data_out, ok ? d : 8'h00);
  endtask
  task test_done;
    $display("compares %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge mclk_in) if (++cycles == 1000) begin
    num_errors++;
    test_done();
  end
  initial begin
    {verify_req_in, verify_addr_in, program_req_in, fetch_external_in} = '0;
    {code_table_read_instruction_in, table_addr_internal_in} = 2'h3;
    for (int lv = 0; lv < 4; lv++) begin
      rstn_in = 1'b0;
      lock_cells_in = {lv > 0, lv > 1, lv > 2};
      enc_programmed_in = lv[0];
      external_access_select_in = 1'b1;
      repeat (20) @(negedge mclk_in);
      rstn_in = 1'b1;
      repeat (4) @(negedge mclk_in);
      external_access_select_in = 1'b0;
      chk(level_out, 8'(lv));
      rd(`PML_SIG_ADDR0, 1'b1, `PML_SIG_VAL0);
      rd(`PML_SIG_ADDR1, 1'b1, `PML_SIG_VAL1);
      rd(`PML_SIG_ADDR2, 1'b1, `PML_SIG_VAL2);
      rd(13'h0123, lv < 2, lv[0] ? ~(8'h1F ^ 8'hC3) : 8'h1F);
      verify_req_in = 1'b0;
      {program_req_in, fetch_external_in} = 2'h3;
      @(negedge mclk_in);
      chk(program_grant_out, lv == 0);
      chk(program_refused_out, lv > 0);
      chk(table_read_block_out, lv > 0);
      chk(fetch_block_out, lv == 3);
      chk(ext_select_out, lv > 0);
      table_addr_internal_in = 1'b0;
      @(negedge mclk_in);
      chk(table_read_block_out, 1'b0);
      table_addr_internal_in = 1'b1;
      {program_req_in, fetch_external_in} = 2'h0;
      $display("level %0d done", lv);
    end
    test_done();
  end
endmodule
